// ---- design/seg_addr_pkg.sv ----
// Constants and types for the segment address generator.
// Assumes a single clock domain and a synchronous reset.
package seg_addr_pkg;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned PHYS_W = 20;
    localparam int unsigned SEG_SHIFT = 4;
    localparam int unsigned NUM_REGS = 14;
    localparam int unsigned REG_IDX_W = 4;
    localparam int unsigned CLK_PERIOD_NS = 40;

    // Register file indices
    localparam logic [3:0] IDX_ACCUM = 4'h0;
    localparam logic [3:0] IDX_COUNT = 4'h1;
    localparam logic [3:0] IDX_DATA = 4'h2;
    localparam logic [3:0] IDX_BASE = 4'h3;
    localparam logic [3:0] IDX_STACK = 4'h4;
    localparam logic [3:0] IDX_FRAME = 4'h5;
    localparam logic [3:0] IDX_SRC = 4'h6;
    localparam logic [3:0] IDX_DEST = 4'h7;
    localparam logic [3:0] IDX_EXTRA_SEG = 4'h8;
    localparam logic [3:0] IDX_CODE_SEG = 4'h9;
    localparam logic [3:0] IDX_STACK_SEG = 4'ha;
    localparam logic [3:0] IDX_DATA_SEG = 4'hb;
    localparam logic [3:0] IDX_INSTR_PTR = 4'hc;
    localparam logic [3:0] IDX_FLAGS = 4'hd;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [15:0] CODE_SEG_RESET = 16'hffff;

    // Write width codes
    localparam logic [1:0] WR_WORD = 2'h0;
    localparam logic [1:0] WR_LOW = 2'h1;
    localparam logic [1:0] WR_HIGH = 2'h2;

    typedef enum logic [1:0] {
        SEG_EXTRA,
        SEG_CODE,
        SEG_STACK,
        SEG_DATA
    } seg_sel_t;

    typedef enum logic [2:0] {
        REF_FETCH,
        REF_IMMED,
        REF_STACK,
        REF_STRING_DEST,
        REF_DATA
    } ref_kind_t;

    typedef enum logic [1:0] {
        BASE_NONE,
        BASE_BASE_GP,
        BASE_FRAME
    } base_sel_t;

    typedef enum logic [1:0] {
        INDEX_NONE,
        INDEX_SRC,
        INDEX_DEST
    } index_sel_t;

    typedef enum logic [1:0] {
        DISP_NONE,
        DISP_8,
        DISP_16
    } disp_sel_t;
endpackage : seg_addr_pkg

// ---- design/arch_reg_file.sv ----
// Fourteen-word architectural register file with byte-half writes.
// Assumes one writer per cycle; read data come from registers.
`timescale 1ns/1ps
`default_nettype none
module arch_reg_file (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        wr_en_i,
    input  wire logic [3:0]  wr_idx_i,
    input  wire logic [1:0]  wr_width_i,
    input  wire logic [15:0] wr_data_i,
    input  wire logic [3:0]  rd_idx_i,
    output logic      [15:0] rd_data_o,
    output logic      [15:0] code_seg_o,
    output logic      [15:0] stack_seg_o,
    output logic      [15:0] data_seg_o,
    output logic      [15:0] extra_seg_o,
    output logic      [15:0] base_gp_o,
    output logic      [15:0] frame_base_o,
    output logic      [15:0] src_index_o,
    output logic      [15:0] dest_index_o,
    output logic      [15:0] stack_top_o,
    output logic      [15:0] instr_ptr_o
);
    logic [15:0] regs_q [seg_addr_pkg::NUM_REGS];

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < seg_addr_pkg::NUM_REGS; g++) begin : g_reg
            localparam logic [3:0] IDX = 4'(g);
            localparam logic [15:0] RST = (IDX == seg_addr_pkg::IDX_CODE_SEG)
                ? seg_addr_pkg::CODE_SEG_RESET : seg_addr_pkg::REG_RESET;
            always_ff @(posedge clk_i) begin
                if (srst_i) begin
                    regs_q[g] <= RST;
                end else if (wr_en_i && wr_idx_i == IDX) begin
                    // Halves only for the four splittable registers
                    if (wr_width_i == seg_addr_pkg::WR_LOW && IDX < 4'h4) begin
                        regs_q[g][7:0] <= wr_data_i[7:0];
                    end else if (wr_width_i == seg_addr_pkg::WR_HIGH && IDX < 4'h4) begin
                        regs_q[g][15:8] <= wr_data_i[7:0];
                    end else begin
                        regs_q[g] <= wr_data_i;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Registered read port
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rd_data_o <= seg_addr_pkg::REG_RESET;
        end else if (rd_idx_i < 4'(seg_addr_pkg::NUM_REGS)) begin
            rd_data_o <= regs_q[rd_idx_i];
        end else begin
            rd_data_o <= seg_addr_pkg::REG_RESET;
        end
    end

    assign code_seg_o   = regs_q[seg_addr_pkg::IDX_CODE_SEG];
    assign stack_seg_o  = regs_q[seg_addr_pkg::IDX_STACK_SEG];
    assign data_seg_o   = regs_q[seg_addr_pkg::IDX_DATA_SEG];
    assign extra_seg_o  = regs_q[seg_addr_pkg::IDX_EXTRA_SEG];
    assign base_gp_o    = regs_q[seg_addr_pkg::IDX_BASE];
    assign frame_base_o = regs_q[seg_addr_pkg::IDX_FRAME];
    assign src_index_o  = regs_q[seg_addr_pkg::IDX_SRC];
    assign dest_index_o = regs_q[seg_addr_pkg::IDX_DEST];
    assign stack_top_o  = regs_q[seg_addr_pkg::IDX_STACK];
    assign instr_ptr_o  = regs_q[seg_addr_pkg::IDX_INSTR_PTR];
endmodule : arch_reg_file
`default_nettype wire

// ---- design/segment_address_generator.sv ----
// Effective and physical address generation with register file.
// Assumes the decoder presents one reference per cycle on req_valid_i
// and the bus interface unit consumes phys_addr_o when addr_valid_o.
`timescale 1ns/1ps
`default_nettype none
module segment_address_generator (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        req_valid_i,
    input  wire logic [2:0]  ref_kind_i,
    input  wire logic [1:0]  base_sel_i,
    input  wire logic [1:0]  index_sel_i,
    input  wire logic [1:0]  disp_sel_i,
    input  wire logic [15:0] disp_i,
    input  wire logic        override_en_i,
    input  wire logic [1:0]  override_seg_i,
    input  wire logic        wr_en_i,
    input  wire logic [3:0]  wr_idx_i,
    input  wire logic [1:0]  wr_width_i,
    input  wire logic [15:0] wr_data_i,
    input  wire logic        opnd_imm_i,
    input  wire logic [3:0]  opnd_idx_i,
    input  wire logic        opnd_byte_i,
    input  wire logic        opnd_high_i,
    input  wire logic [15:0] opnd_imm_data_i,
    output logic             addr_valid_o,
    output logic      [19:0] phys_addr_o,
    output logic      [15:0] eff_addr_o,
    output logic      [1:0]  seg_used_o,
    output logic      [15:0] operand_o
);
    logic [15:0] code_seg;
    logic [15:0] stack_seg;
    logic [15:0] data_seg_reg;
    logic [15:0] extra_seg_reg;
    logic [15:0] base_gp_reg;
    logic [15:0] frame_base_ptr;
    logic [15:0] src_index_reg;
    logic [15:0] dest_index_reg;
    logic [15:0] stack_top_ptr;
    logic [15:0] instr_ptr;
    logic [15:0] rd_data;
    logic        opnd_imm_q;
    logic        opnd_byte_q;
    logic        opnd_high_q;
    logic [15:0] opnd_imm_data_q;
    logic [15:0] base_val;
    logic [15:0] index_val;
    logic [15:0] disp_val;
    logic [15:0] offset;
    logic [15:0] seg_base;
    seg_addr_pkg::seg_sel_t seg_sel;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    arch_reg_file u_regs (
        .clk_i        (clk_i),
        .srst_i       (srst_i),
        .wr_en_i      (wr_en_i),
        .wr_idx_i     (wr_idx_i),
        .wr_width_i   (wr_width_i),
        .wr_data_i    (wr_data_i),
        .rd_idx_i     (opnd_idx_i),
        .rd_data_o    (rd_data),
        .code_seg_o   (code_seg),
        .stack_seg_o  (stack_seg),
        .data_seg_o   (data_seg_reg),
        .extra_seg_o  (extra_seg_reg),
        .base_gp_o    (base_gp_reg),
        .frame_base_o (frame_base_ptr),
        .src_index_o  (src_index_reg),
        .dest_index_o (dest_index_reg),
        .stack_top_o  (stack_top_ptr),
        .instr_ptr_o  (instr_ptr)
    );

    // ------------------------------------------------------------
    // Segment selection
    // ------------------------------------------------------------
    function automatic seg_addr_pkg::seg_sel_t implicit_seg(
        input logic [2:0] kind,
        input logic [1:0] bsel
    );
        seg_addr_pkg::seg_sel_t s;
        s = seg_addr_pkg::SEG_DATA;
        if (kind == 3'(seg_addr_pkg::REF_FETCH) || kind == 3'(seg_addr_pkg::REF_IMMED)) begin
            s = seg_addr_pkg::SEG_CODE;
        end else if (kind == 3'(seg_addr_pkg::REF_STACK)
                     || bsel == 2'(seg_addr_pkg::BASE_FRAME)) begin
            s = seg_addr_pkg::SEG_STACK;
        end else if (kind == 3'(seg_addr_pkg::REF_STRING_DEST)) begin
            s = seg_addr_pkg::SEG_EXTRA;
        end
        return s;
    endfunction

    // Fetches and immediates ignore overrides; prefixes only steer stack, string and data references
    always_comb begin
        seg_sel = implicit_seg(ref_kind_i, base_sel_i);
        if (override_en_i && ref_kind_i != 3'(seg_addr_pkg::REF_FETCH)
            && ref_kind_i != 3'(seg_addr_pkg::REF_IMMED)) begin
            seg_sel = seg_addr_pkg::seg_sel_t'(override_seg_i);
        end
    end

    always_comb begin
        unique case (seg_sel)
            seg_addr_pkg::SEG_EXTRA: seg_base = extra_seg_reg;
            seg_addr_pkg::SEG_CODE:  seg_base = code_seg;
            seg_addr_pkg::SEG_STACK: seg_base = stack_seg;
            seg_addr_pkg::SEG_DATA:  seg_base = data_seg_reg;
        endcase
    end

    // ------------------------------------------------------------
    // Effective address
    // ------------------------------------------------------------
    always_comb begin
        base_val = 16'h0000;
        if (base_sel_i == 2'(seg_addr_pkg::BASE_BASE_GP)) begin
            base_val = base_gp_reg;
        end else if (base_sel_i == 2'(seg_addr_pkg::BASE_FRAME)) begin
            base_val = frame_base_ptr;
        end
    end

    always_comb begin
        index_val = 16'h0000;
        if (index_sel_i == 2'(seg_addr_pkg::INDEX_SRC)) begin
            index_val = src_index_reg;
        end else if (index_sel_i == 2'(seg_addr_pkg::INDEX_DEST)) begin
            index_val = dest_index_reg;
        end
    end

    always_comb begin
        disp_val = 16'h0000;
        if (disp_sel_i == 2'(seg_addr_pkg::DISP_8)) begin
            disp_val = {{8{disp_i[7]}}, disp_i[7:0]};
        end else if (disp_sel_i == 2'(seg_addr_pkg::DISP_16)) begin
            disp_val = disp_i;
        end
    end

    // Fetch and stack references take their offset from pointers
    always_comb begin
        if (ref_kind_i == 3'(seg_addr_pkg::REF_FETCH)) begin
            offset = instr_ptr;
        end else if (ref_kind_i == 3'(seg_addr_pkg::REF_STACK)) begin
            offset = stack_top_ptr;
        end else begin
            offset = 16'(disp_val + base_val + index_val);
        end
    end

    // ------------------------------------------------------------
    // Address outputs, one cycle after the request
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            addr_valid_o <= 1'b0;
            phys_addr_o  <= 20'h00000;
            eff_addr_o   <= 16'h0000;
            seg_used_o   <= 2'h0;
        end else begin
            addr_valid_o <= req_valid_i;
            if (req_valid_i) begin
                phys_addr_o <= 20'({seg_base, 4'h0} + {4'h0, offset});
                eff_addr_o  <= offset;
                seg_used_o  <= 2'(seg_sel);
            end
        end
    end

    // ------------------------------------------------------------
    // Non-memory operand path; register read is one cycle late
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            opnd_imm_q      <= 1'b0;
            opnd_byte_q     <= 1'b0;
            opnd_high_q     <= 1'b0;
            opnd_imm_data_q <= 16'h0000;
        end else begin
            opnd_imm_q      <= opnd_imm_i;
            opnd_byte_q     <= opnd_byte_i;
            opnd_high_q     <= opnd_high_i;
            opnd_imm_data_q <= opnd_imm_data_i;
        end
    end

    always_comb begin
        if (opnd_imm_q) begin
            operand_o = opnd_imm_data_q;
        end else if (opnd_byte_q && opnd_high_q) begin
            operand_o = {8'h00, rd_data[15:8]};
        end else if (opnd_byte_q) begin
            operand_o = {8'h00, rd_data[7:0]};
        end else begin
            operand_o = rd_data;
        end
    end
endmodule : segment_address_generator
`default_nettype wire

// ---- sim/seg_addr_assertions.sv ----
// Port checker for the segment address generator.
// Assumes it is bound to segment_address_generator; one clock.
`timescale 1ns/1ps
`default_nettype none
module seg_addr_assertions (
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic        req_valid_i,
    input wire logic [2:0]  ref_kind_i,
    input wire logic [1:0]  base_sel_i,
    input wire logic [1:0]  index_sel_i,
    input wire logic [1:0]  disp_sel_i,
    input wire logic [15:0] disp_i,
    input wire logic        override_en_i,
    input wire logic [1:0]  override_seg_i,
    input wire logic        addr_valid_o,
    input wire logic [19:0] phys_addr_o,
    input wire logic [15:0] eff_addr_o,
    input wire logic [1:0]  seg_used_o
);
    // ----------------------------------------
    // Helpers and sequences
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    logic [15:0] disp_q;
    always_ff @(posedge clk_i) begin
        disp_q <= disp_i;
    end
    sequence s_disp_only;
        req_valid_i && ref_kind_i == 3'h4 && base_sel_i == 2'h0 && index_sel_i == 2'h0;
    endsequence
    sequence s_answer;
        ##1 addr_valid_o;
    endsequence
    wire plain_w = req_valid_i && !override_en_i;
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_answer_next: assert property (req_valid_i |-> s_answer) else $error("no answer");
    a_no_stray: assert property (!req_valid_i |=> !addr_valid_o) else $error("stray valid");
    a_reset_clear: assert property (disable iff (1'b0) srst_i |=> !addr_valid_o && phys_addr_o == 20'h00000)
        else $error("reset not clear");
    a_fetch_code: assert property (req_valid_i && ref_kind_i <= 3'h1 |=> seg_used_o == 2'h1)
        else $error("fetch not code");
    a_stack_seg: assert property (plain_w && (ref_kind_i == 3'h2 || (ref_kind_i == 3'h4
        && base_sel_i == 2'h2)) |=> seg_used_o == 2'h2) else $error("not stack");
    a_string_extra: assert property (plain_w && ref_kind_i == 3'h3 && base_sel_i != 2'h2
        |=> seg_used_o == 2'h0) else $error("not extra");
    a_data_default: assert property (plain_w && ref_kind_i == 3'h4 && base_sel_i != 2'h2
        |=> seg_used_o == 2'h3) else $error("not data");
    a_override_seg: assert property (req_valid_i && override_en_i && ref_kind_i >= 3'h2
        |=> seg_used_o == $past(override_seg_i)) else $error("override lost");
    a_disp_word: assert property (s_disp_only ##0 disp_sel_i == 2'h2 |=> eff_addr_o == disp_q)
        else $error("disp16 wrong");
    a_disp_sext: assert property (s_disp_only ##0 disp_sel_i == 2'h1
        |=> eff_addr_o == {{8{disp_q[7]}}, disp_q[7:0]}) else $error("disp8 not extended");
    // Segment base is shifted, so the low nibble is the offset's
    a_phys_nibble: assert property (addr_valid_o |-> phys_addr_o[3:0] == eff_addr_o[3:0])
        else $error("low nibble wrong");
endmodule // seg_addr_assertions
bind segment_address_generator seg_addr_assertions i_chk (.clk_i, .srst_i, .req_valid_i,
    .ref_kind_i, .base_sel_i, .index_sel_i, .disp_sel_i, .disp_i, .override_en_i,
    .override_seg_i, .addr_valid_o, .phys_addr_o, .eff_addr_o, .seg_used_o);
`default_nettype wire

// ---- sim/bus_unit_model.sv ----
// Bus interface unit stand-in: takes each issued address.
// Assumes one address per addr_valid_i pulse; no back-pressure.
`timescale 1ns/1ps
`default_nettype none
module bus_unit_model (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        addr_valid_i,
    input  wire logic [19:0] phys_addr_i,
    output logic      [15:0] cycles_o,
    output logic      [19:0] last_addr_o
);
    // Counting cycles exposes extra or missing valid pulses
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cycles_o <= 16'h0000;
        end else if (addr_valid_i) begin
            cycles_o <= cycles_o + 16'h0001;
        end
    end
    always_ff @(posedge clk_i) begin
        if (addr_valid_i) begin
            last_addr_o <= phys_addr_i;
        end
    end
endmodule // bus_unit_model
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench for the segment address generator.
// Assumes inputs driven at the falling edge, one request at a time.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_top;
    logic        clk_i = 1'b0, srst_i = 1'b1, req_valid_i = 1'b0, override_en_i = 1'b0;
    logic        wr_en_i = 1'b0, opnd_imm_i = 1'b0, opnd_byte_i = 1'b0, opnd_high_i = 1'b0;
    logic [2:0]  ref_kind_i = 3'h0;
    logic [1:0]  base_sel_i = 2'h0, index_sel_i = 2'h0, disp_sel_i = 2'h0, override_seg_i = 2'h0;
    logic [1:0]  wr_width_i = 2'h0, seg_used_o;
    logic [3:0]  wr_idx_i = 4'h0, opnd_idx_i = 4'h0;
    logic [15:0] disp_i = 16'h0000, wr_data_i = 16'h0000, opnd_imm_data_i = 16'h0000;
    logic [15:0] eff_addr_o, operand_o, cycles_w;
    logic [19:0] phys_addr_o, last_w;
    logic        addr_valid_o;
    int          failures = 0, num_checks = 0, n_req = 0;
    initial forever #20 clk_i = ~clk_i;
    segment_address_generator i_dut (.clk_i, .srst_i, .req_valid_i, .ref_kind_i, .base_sel_i,
        .index_sel_i, .disp_sel_i, .disp_i, .override_en_i, .override_seg_i, .wr_en_i,
        .wr_idx_i, .wr_width_i, .wr_data_i, .opnd_imm_i, .opnd_idx_i, .opnd_byte_i,
        .opnd_high_i, .opnd_imm_data_i, .addr_valid_o, .phys_addr_o, .eff_addr_o,
        .seg_used_o, .operand_o);
    bus_unit_model i_bus (.clk_i, .srst_i, .addr_valid_i(addr_valid_o),
        .phys_addr_i(phys_addr_o), .cycles_o(cycles_w), .last_addr_o(last_w));
    // ----------------------------------------
    // Drivers
    // ----------------------------------------
    task automatic wr(input logic [3:0] idx, input logic [1:0] w, input logic [15:0] d);
        @(negedge clk_i);
        {wr_en_i, wr_idx_i, wr_width_i, wr_data_i} = {1'b1, idx, w, d};
        @(negedge clk_i);
        wr_en_i = 1'b0;
    endtask
    task automatic req(input logic [2:0] k, input logic [1:0] b, x, ds, input logic [15:0] dv,
        input logic ov, input logic [1:0] os, input logic [15:0] off, input logic [1:0] sc,
        input logic [15:0] sv);
        @(negedge clk_i);
        {req_valid_i, ref_kind_i, base_sel_i, index_sel_i, disp_sel_i} = {1'b1, k, b, x, ds};
        {disp_i, override_en_i, override_seg_i} = {dv, ov, os};
        @(negedge clk_i);
        req_valid_i = 1'b0;
        n_req++;
        `CHK(addr_valid_o, 1'b1)
        `CHK(eff_addr_o, off)
        `CHK(seg_used_o, sc)
        `CHK(phys_addr_o, {sv, 4'h0} + {4'h0, off})
    endtask
    task automatic opnd(input logic im, input logic [3:0] idx, input logic by, hi,
        input logic [15:0] imd, exp_v);
        @(negedge clk_i);
        {opnd_imm_i, opnd_idx_i, opnd_byte_i, opnd_high_i, opnd_imm_data_i} = {im, idx, by, hi, imd};
        @(negedge clk_i);
        `CHK(operand_o, exp_v)
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        `CHK(addr_valid_o, 1'b0)
        `CHK(phys_addr_o, 20'h00000)
        `CHK(operand_o, 16'h0000)
        req(3'h0, 2'h0, 2'h0, 2'h0, 16'h0000, 1'b0, 2'h0, 16'h0000, 2'h1, 16'hffff);
    endtask
    task automatic t_halves;
        wr(4'h0, 2'h0, 16'h1111);
        wr(4'h0, 2'h1, 16'h00ab);
        wr(4'h0, 2'h2, 16'h00cd);
        opnd(1'b0, 4'h0, 1'b0, 1'b0, 16'h0000, 16'hcdab);
        opnd(1'b0, 4'h0, 1'b1, 1'b0, 16'h0000, 16'h00ab);
        opnd(1'b0, 4'h0, 1'b1, 1'b1, 16'h0000, 16'h00cd);
        opnd(1'b1, 4'h0, 1'b0, 1'b0, 16'h5a5a, 16'h5a5a);
    endtask
    task automatic t_addressing;
        wr(4'h3, 2'h0, 16'h1234);
        wr(4'h5, 2'h0, 16'hfff0);
        wr(4'h6, 2'h0, 16'h0100);
        wr(4'h7, 2'h0, 16'h0020);
        wr(4'h4, 2'h0, 16'h0200);
        wr(4'hb, 2'h0, 16'h2000);
        wr(4'ha, 2'h0, 16'h3000);
        wr(4'h8, 2'h0, 16'h4000);
        wr(4'hc, 2'h0, 16'h0010);
        req(3'h4, 2'h1, 2'h1, 2'h2, 16'h0010, 1'b0, 2'h0, 16'h1344, 2'h3, 16'h2000);
        req(3'h4, 2'h2, 2'h2, 2'h1, 16'h0080, 1'b0, 2'h0, 16'hff90, 2'h2, 16'h3000);
        req(3'h4, 2'h0, 2'h1, 2'h1, 16'h007f, 1'b0, 2'h0, 16'h017f, 2'h3, 16'h2000);
        req(3'h3, 2'h0, 2'h2, 2'h0, 16'h0000, 1'b0, 2'h0, 16'h0020, 2'h0, 16'h4000);
        req(3'h2, 2'h0, 2'h0, 2'h0, 16'h0000, 1'b0, 2'h0, 16'h0200, 2'h2, 16'h3000);
        req(3'h2, 2'h0, 2'h0, 2'h0, 16'h0000, 1'b1, 2'h0, 16'h0200, 2'h0, 16'h4000);
        req(3'h4, 2'h1, 2'h0, 2'h0, 16'h0000, 1'b1, 2'h1, 16'h1234, 2'h1, 16'hffff);
        req(3'h0, 2'h0, 2'h0, 2'h0, 16'h0000, 1'b1, 2'h3, 16'h0010, 2'h1, 16'hffff);
        req(3'h1, 2'h0, 2'h0, 2'h0, 16'h0000, 1'b0, 2'h0, 16'h0000, 2'h1, 16'hffff);
        req(3'h4, 2'h0, 2'h0, 2'h1, 16'h0080, 1'b0, 2'h0, 16'hff80, 2'h3, 16'h2000);
        req(3'h4, 2'h0, 2'h0, 2'h2, 16'hffff, 1'b0, 2'h0, 16'hffff, 2'h3, 16'h2000);
        // Bus model takes the last pulse on the next rising edge
        @(negedge clk_i);
        `CHK(cycles_w, 16'(n_req))
        `CHK(last_w, 20'h2ffff)
    endtask
    // ----------------------------------------
    // Sequence and verdict
    // ----------------------------------------
    task automatic final_report;
        $display("checks %0d, failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clk_i);
        srst_i = 1'b0;
        t_reset();
        t_halves();
        t_addressing();
        final_report();
    end
    // Hang guard: a run past this bound counts as a mismatch
    initial begin
        repeat (5000) @(posedge clk_i);
        failures++;
        final_report();
    end
endmodule // tb_top
`default_nettype wire
